// ==== src/supc_pkg.sv ====
/*
 shared register map, field layouts, reset values and state types of the supply mode
 and wake-up control block.
 assumes one core clock and a slow-clock tick made elsewhere.
*/
`default_nettype none

package supc_pkg;

	// ==========
	// register map
	localparam logic [7:0] MODE_OFFSET = 8'h08;
	localparam logic [7:0] WAKE_MODE_OFFSET = 8'h0c;
	localparam logic [7:0] WAKE_INPUT_OFFSET = 8'h10;
	localparam logic [7:0] STATUS_OFFSET = 8'h20;
	localparam logic [7:0] WRITE_KEY = 8'ha5;
	localparam logic [31:0] MODE_RESET = 32'h0008_0a00;
	localparam logic [31:0] MODE_WRITE_MASK = 32'h001e_1f3f;
	localparam logic [31:0] WAKE_MODE_WRITE_MASK = 32'h0000_770b;
	localparam int NUM_WAKE_MAX = 16;

	// ==========
	// field codes
	localparam logic [1:0] LCD_OFF_NOW = 2'h0;
	localparam logic [1:0] LCD_OFF_AT_EOF = 2'h1;
	localparam logic [1:0] LCD_EXTERNAL = 2'h2;
	localparam logic [1:0] LCD_INTERNAL = 2'h3;
	localparam logic [2:0] REG_LEVEL_LOWEST = 3'h2;
	localparam logic [2:0] REG_LEVEL_HIGHEST = 3'h5;
	localparam logic [2:0] BOD_DISABLED = 3'h0;

	// ==========
	// debounce limits in slow-clock periods, zero never accepts
	localparam logic [15:0] DEBOUNCE_NONE = 16'h0001;
	localparam logic [15:0] DEBOUNCE_3 = 16'h0003;
	localparam logic [15:0] DEBOUNCE_32 = 16'h0020;
	localparam logic [15:0] DEBOUNCE_512 = 16'h0200;
	localparam logic [15:0] DEBOUNCE_4096 = 16'h1000;
	localparam logic [15:0] DEBOUNCE_LONGEST = 16'h8000;
	localparam logic [15:0] DEBOUNCE_NEVER = 16'h0000;

	// ==========
	// types
	typedef struct packed {
		logic [7:0] key;
		logic [2:0] unused3;
		logic crystal_bypass;
		logic flash_power_on;
		logic rtc_alarm_power_on;
		logic backup_ram_power_on;
		logic unused2;
		logic [2:0] unused1;
		logic regulation_loss_reset_enable;
		logic [2:0] regulator_level_select;
		logic regulator_deep_enable;
		logic [1:0] unused0;
		logic [1:0] lcd_supply_select;
		logic [3:0] lcd_pump_level;
	} supply_mode_type;

	typedef struct packed {
		logic [16:0] unused3;
		logic [2:0] input_wake_debounce_field;
		logic unused2;
		logic [2:0] force_wake_debounce;
		logic [3:0] unused1;
		logic rtc_wake_enable;
		logic unused0;
		logic brownout_wake_enable;
		logic force_wake_enable;
	} wake_mode_type;

	typedef struct packed {
		logic [15:0] wake_input_polarity;
		logic [15:0] wake_input_enable;
	} wake_input_type;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [31:0] wdata;
	} bus_req_type;

	typedef struct packed {
		logic armed;
		logic [15:0] count;
		logic hit;
	} debounce_state_type;

	typedef struct packed {
		supply_mode_type mode;
		wake_mode_type wake_mode;
		wake_input_type inputs;
		logic [31:0] rdata;
		logic lcd_ext;
		logic lcd_int;
		logic pump;
		logic [2:0] reg_level;
		logic core_reset;
		logic xtal_cmd_seen;
		logic slow_xtal;
		logic wake;
	} core_state_type;

	localparam supply_mode_type MODE_RESET_FIELDS = supply_mode_type'(MODE_RESET);
	localparam core_state_type STATE_RESET = '{
		mode: MODE_RESET_FIELDS,
		reg_level: MODE_RESET_FIELDS.regulator_level_select,
		default: '0
	};

	// both debounce fields share this decode; reserved codes never accept
	function automatic logic [15:0] debounce_limit(input logic [2:0] code, input logic [15:0] longest);
		logic [15:0] limit;
		limit = DEBOUNCE_NEVER;
		case (code)
			3'h0: limit = DEBOUNCE_NONE;
			3'h1: limit = DEBOUNCE_3;
			3'h2: limit = DEBOUNCE_32;
			3'h3: limit = DEBOUNCE_512;
			3'h4: limit = DEBOUNCE_4096;
			3'h5: limit = longest;
			default: limit = DEBOUNCE_NEVER;
		endcase
		return limit;
	endfunction

endpackage

`default_nettype wire

// ==== src/wake_debounce.sv ====
/*
 one wake source debouncer counting slow-clock ticks while the source is active.
 assumes tick_i is a one-cycle pulse per slow-clock edge in the core clock domain.
*/
`default_nettype none

module wake_debounce (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic en_i,
	input wire logic tick_i,
	input wire logic active_i,
	input wire logic edge_i,
	input wire logic [15:0] limit_i,
	output logic hit_o
);

	supc_pkg::debounce_state_type s_q;
	supc_pkg::debounce_state_type s_d;

	// ==========
	// counting
	always_comb
	begin
		s_d = s_q;
		if (tick_i)
		begin
			// an edge source must be seen idle before it may count
			if (!active_i)
			begin
				s_d.armed = 1'b1;
				s_d.count = 16'h0000;
				s_d.hit = 1'b0;
			end
			else if ((s_q.armed || !edge_i) && limit_i != supc_pkg::DEBOUNCE_NEVER)
			begin
				if (s_q.count < limit_i)
				begin
					s_d.count = s_q.count + 16'h0001;
				end
				s_d.hit = (s_d.count >= limit_i);
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_q <= '0;
		end
		else if (en_i)
		begin
			s_q <= s_d;
		end
	end

	assign hit_o = s_q.hit;

	// ==========
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_no_debounce;
		(en_i && tick_i && active_i && !edge_i && limit_i == supc_pkg::DEBOUNCE_NONE) |=> hit_o;
	endproperty
	a_no_debounce: assert property (p_no_debounce) else $error("undebounced source not accepted");

	property p_idle_drops;
		(en_i && tick_i && !active_i) |=> !hit_o;
	endproperty
	a_idle_drops: assert property (p_idle_drops) else $error("idle source still accepted");

endmodule

`default_nettype wire

// ==== src/supply_mode_and_wakeup_control.sv ====
/*
 supply mode register, wake source configuration and core wake-up decision.
 assumes all pins are synchronous to the core clock and SLOW_CLOCK_TICK_I pulses once
 per slow-clock period.
*/
`default_nettype none

// How it works
// - lcd code 0 drops both sources and pump, 2 external, 3 internal with pump.
// - lcd code 1 drops sources and pump only at lcd end of frame.
// - deep-mode bit drives the regulator deep-mode output.
// - level codes 0 and 1 ignored, 2 to 4 rising, 5 to 7 highest.
// - regulation loss raises core reset only when its enable is set.
// - backup ram power bit drives backup ram switch.
// - rtc alarm power bit drives rtc alarm switch.
// - flash power bit drives flash switch.
// - bypass selects crystal in bypass; otherwise crystal-select command decides.
// - supply mode writes take effect only with key 0xa5.
// - enabled force-wake pin held low wakes the core.
// - enabled brownout alarm wakes the core.
// - enabled rtc alarm wakes the core.
// - force-wake pin debounce of 3, 32, 512, 4096 or 32768 slow periods.
// - wake input debounce of 3, 32, 512, 4096 or 32768 slow periods.
// - debounce code 0 accepts a source on one slow edge.
// - each wake input has its own enable bit.
// - polarity 0 wakes on falling transition, 1 on rising transition.
// - enables sit in bits 0 to 15, polarities in 16 to 31.
// - brownout wakes only while its sampling period is nonzero.
module supply_mode_and_wakeup_control #(
	parameter int NUM_WAKE = 16,
	parameter logic [15:0] LONGEST_DEBOUNCE = supc_pkg::DEBOUNCE_LONGEST
) (
	input wire logic CORE_CLK_I,
	input wire logic RESET_I,
	input wire logic CLK_EN_I,
	input wire logic SLOW_CLOCK_TICK_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic LCD_EOF_I,
	input wire logic REG_LOSS_I,
	input wire logic CRYSTAL_SELECT_CMD_I,
	input wire logic FORCE_WAKE_PIN_N_I,
	input wire logic BROWNOUT_ALARM_I,
	input wire logic [2:0] BROWNOUT_SAMPLE_PERIOD_I,
	input wire logic RTC_ALARM_I,
	input wire logic [NUM_WAKE-1:0] WAKE_IN_I,
	output logic [31:0] RDATA_O,
	output logic LCD_EXT_SEL_O,
	output logic LCD_INT_SEL_O,
	output logic CHARGE_PUMP_ON_O,
	output logic [3:0] LCD_PUMP_LEVEL_O,
	output logic REG_DEEP_O,
	output logic [2:0] REG_LEVEL_O,
	output logic CORE_RESET_O,
	output logic BACKUP_RAM_ON_O,
	output logic RTC_POWER_ON_O,
	output logic FLASH_POWER_ON_O,
	output logic CRYSTAL_BYPASS_O,
	output logic SLOW_SRC_CRYSTAL_O,
	output logic WAKE_REQ_O
);

	// ==========
	// elaboration checks
	if (NUM_WAKE < 1 || NUM_WAKE > supc_pkg::NUM_WAKE_MAX)
	begin : g_bad_count
		$error("wake input count out of range");
	end
	if (LONGEST_DEBOUNCE == supc_pkg::DEBOUNCE_NEVER)
	begin : g_bad_debounce
		$error("longest debounce must be nonzero");
	end

	localparam logic [15:0] IN_MASK = 16'((17'h00001 << NUM_WAKE) - 17'h00001);

	supc_pkg::core_state_type s_q;
	supc_pkg::core_state_type s_d;
	supc_pkg::bus_req_type req;
	supc_pkg::supply_mode_type wr_mode;
	logic [NUM_WAKE-1:0] in_active;
	logic [NUM_WAKE-1:0] in_hit;
	logic [15:0] in_hit_all;
	logic force_hit;
	logic bod_wake;
	logic rtc_wake;
	logic [15:0] force_limit;
	logic [15:0] input_limit;

	assign req = '{rd: RD_I, wr: WR_I, addr: ADDR_I, wdata: WDATA_I};
	assign wr_mode = supc_pkg::supply_mode_type'(WDATA_I);

	// ==========
	// wake sources
	assign force_limit = supc_pkg::debounce_limit(s_q.wake_mode.force_wake_debounce, LONGEST_DEBOUNCE);
	assign input_limit = supc_pkg::debounce_limit(s_q.wake_mode.input_wake_debounce_field, LONGEST_DEBOUNCE);

	assign in_active = s_q.inputs.wake_input_enable[NUM_WAKE-1:0]
		& ~(WAKE_IN_I ^ s_q.inputs.wake_input_polarity[NUM_WAKE-1:0]);
	assign in_hit_all = 16'(in_hit);

	wake_debounce u_force_debounce (
		.clk_i(CORE_CLK_I),
		.rst_i(RESET_I),
		.en_i(CLK_EN_I),
		.tick_i(SLOW_CLOCK_TICK_I),
		.active_i(s_q.wake_mode.force_wake_enable && !FORCE_WAKE_PIN_N_I),
		.edge_i(1'b0),
		.limit_i(force_limit),
		.hit_o(force_hit)
	);

	// one debouncer per wake input, each needs a transition
	for (genvar i = 0; i < NUM_WAKE; i++)
	begin : g_wake
		wake_debounce u_input_debounce (
			.clk_i(CORE_CLK_I),
			.rst_i(RESET_I),
			.en_i(CLK_EN_I),
			.tick_i(SLOW_CLOCK_TICK_I),
			.active_i(in_active[i]),
			.edge_i(1'b1),
			.limit_i(input_limit),
			.hit_o(in_hit[i])
		);
	end

	assign bod_wake = s_q.wake_mode.brownout_wake_enable && BROWNOUT_ALARM_I
		&& BROWNOUT_SAMPLE_PERIOD_I != supc_pkg::BOD_DISABLED;
	// rtc alarm gated by its enable
	assign rtc_wake = s_q.wake_mode.rtc_wake_enable && RTC_ALARM_I;

	// ==========
	// next state
	always_comb
	begin
		s_d = s_q;
		// read data stand for one cycle only
		s_d.rdata = 32'h0000_0000;

		if (req.wr)
		begin
			// a wrong key drops the whole supply mode write
			if (req.addr == supc_pkg::MODE_OFFSET && wr_mode.key == supc_pkg::WRITE_KEY)
			begin
				s_d.mode = supc_pkg::supply_mode_type'(req.wdata & supc_pkg::MODE_WRITE_MASK);
			end
			if (req.addr == supc_pkg::WAKE_MODE_OFFSET)
			begin
				s_d.wake_mode = supc_pkg::wake_mode_type'(req.wdata & supc_pkg::WAKE_MODE_WRITE_MASK);
			end
			// enables low half, polarities high half
			if (req.addr == supc_pkg::WAKE_INPUT_OFFSET)
			begin
				s_d.inputs = supc_pkg::wake_input_type'(req.wdata & {IN_MASK, IN_MASK});
			end
		end

		if (req.rd)
		begin
			case (req.addr)
				supc_pkg::MODE_OFFSET: s_d.rdata = s_q.mode;
				supc_pkg::WAKE_MODE_OFFSET: s_d.rdata = s_q.wake_mode;
				supc_pkg::WAKE_INPUT_OFFSET: s_d.rdata = s_q.inputs;
				supc_pkg::STATUS_OFFSET: s_d.rdata = {in_hit_all, 12'h000, s_q.slow_xtal,
					s_q.mode.lcd_supply_select == supc_pkg::LCD_OFF_AT_EOF && (s_q.lcd_ext || s_q.lcd_int),
					force_hit, s_q.wake};
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end

		unique case (s_q.mode.lcd_supply_select)
			supc_pkg::LCD_OFF_NOW:
			begin
				s_d.lcd_ext = 1'b0;
				s_d.lcd_int = 1'b0;
				s_d.pump = 1'b0;
			end
			// hold until the lcd frame ends
			supc_pkg::LCD_OFF_AT_EOF:
			begin
				if (LCD_EOF_I)
				begin
					s_d.lcd_ext = 1'b0;
					s_d.lcd_int = 1'b0;
					s_d.pump = 1'b0;
				end
			end
			supc_pkg::LCD_EXTERNAL:
			begin
				s_d.lcd_ext = 1'b1;
				s_d.lcd_int = 1'b0;
				s_d.pump = 1'b0;
			end
			supc_pkg::LCD_INTERNAL:
			begin
				s_d.lcd_ext = 1'b0;
				s_d.lcd_int = 1'b1;
				s_d.pump = 1'b1;
			end
		endcase

		// codes 0 and 1 keep the last level, codes above the highest map to the highest
		if (s_q.mode.regulator_level_select >= supc_pkg::REG_LEVEL_HIGHEST)
		begin
			s_d.reg_level = supc_pkg::REG_LEVEL_HIGHEST;
		end
		else if (s_q.mode.regulator_level_select >= supc_pkg::REG_LEVEL_LOWEST)
		begin
			s_d.reg_level = s_q.mode.regulator_level_select;
		end

		s_d.core_reset = REG_LOSS_I && s_q.mode.regulation_loss_reset_enable;

		if (CRYSTAL_SELECT_CMD_I)
		begin
			s_d.xtal_cmd_seen = 1'b1;
		end
		s_d.slow_xtal = s_q.mode.crystal_bypass || s_q.xtal_cmd_seen;

		// request moves only on slow edges
		if (SLOW_CLOCK_TICK_I)
		begin
			s_d.wake = force_hit || bod_wake || rtc_wake || (|in_hit);
		end
	end

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RESET_I)
		begin
			s_q <= supc_pkg::STATE_RESET;
		end
		else if (CLK_EN_I)
		begin
			s_q <= s_d;
		end
	end

	// ==========
	// outputs, all from the state register
	assign RDATA_O = s_q.rdata;
	assign LCD_EXT_SEL_O = s_q.lcd_ext;
	assign LCD_INT_SEL_O = s_q.lcd_int;
	assign CHARGE_PUMP_ON_O = s_q.pump;
	assign LCD_PUMP_LEVEL_O = s_q.mode.lcd_pump_level;
	assign REG_DEEP_O = s_q.mode.regulator_deep_enable;
	assign REG_LEVEL_O = s_q.reg_level;
	assign CORE_RESET_O = s_q.core_reset;
	assign BACKUP_RAM_ON_O = s_q.mode.backup_ram_power_on;
	assign RTC_POWER_ON_O = s_q.mode.rtc_alarm_power_on;
	assign FLASH_POWER_ON_O = s_q.mode.flash_power_on;
	assign CRYSTAL_BYPASS_O = s_q.mode.crystal_bypass;
	assign SLOW_SRC_CRYSTAL_O = s_q.slow_xtal;
	assign WAKE_REQ_O = s_q.wake;

	// ==========
	// checks
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RESET_I);

	property p_lcd_off;
		(CLK_EN_I && s_q.mode.lcd_supply_select == supc_pkg::LCD_OFF_NOW)
			|=> !LCD_EXT_SEL_O && !LCD_INT_SEL_O && !CHARGE_PUMP_ON_O;
	endproperty
	a_lcd_off: assert property (p_lcd_off) else $error("lcd supply not dropped");

	property p_lcd_internal;
		(CLK_EN_I && s_q.mode.lcd_supply_select == supc_pkg::LCD_INTERNAL)
			|=> LCD_INT_SEL_O && CHARGE_PUMP_ON_O && !LCD_EXT_SEL_O;
	endproperty
	a_lcd_internal: assert property (p_lcd_internal) else $error("internal lcd supply wrong");

	property p_lcd_hold;
		(CLK_EN_I && s_q.mode.lcd_supply_select == supc_pkg::LCD_OFF_AT_EOF && !LCD_EOF_I)
			|=> $stable({LCD_EXT_SEL_O, LCD_INT_SEL_O, CHARGE_PUMP_ON_O});
	endproperty
	a_lcd_hold: assert property (p_lcd_hold) else $error("lcd supply changed before frame end");

	property p_lcd_eof;
		(CLK_EN_I && s_q.mode.lcd_supply_select == supc_pkg::LCD_OFF_AT_EOF && LCD_EOF_I)
			|=> !LCD_EXT_SEL_O && !LCD_INT_SEL_O && !CHARGE_PUMP_ON_O;
	endproperty
	a_lcd_eof: assert property (p_lcd_eof) else $error("lcd supply kept after frame end");

	property p_deep;
		(CLK_EN_I && WR_I && ADDR_I == supc_pkg::MODE_OFFSET && wr_mode.key == supc_pkg::WRITE_KEY)
			|=> REG_DEEP_O == $past(wr_mode.regulator_deep_enable);
	endproperty
	a_deep: assert property (p_deep) else $error("deep mode not taken from keyed write");

	property p_bad_key;
		(CLK_EN_I && WR_I && ADDR_I == supc_pkg::MODE_OFFSET && wr_mode.key != supc_pkg::WRITE_KEY)
			|=> $stable(s_q.mode);
	endproperty
	a_bad_key: assert property (p_bad_key) else $error("write with wrong key changed mode");

	property p_level_top;
		(CLK_EN_I && s_q.mode.regulator_level_select >= supc_pkg::REG_LEVEL_HIGHEST)
			|=> REG_LEVEL_O == supc_pkg::REG_LEVEL_HIGHEST;
	endproperty
	a_level_top: assert property (p_level_top) else $error("top level codes not mapped");

	property p_loss_reset;
		(CLK_EN_I && REG_LOSS_I) |=> CORE_RESET_O == $past(s_q.mode.regulation_loss_reset_enable);
	endproperty
	a_loss_reset: assert property (p_loss_reset) else $error("core reset wrong on regulation loss");

	property p_bypass;
		(CLK_EN_I && s_q.mode.crystal_bypass) |=> SLOW_SRC_CRYSTAL_O;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass did not select crystal");

	property p_brownout;
		(CLK_EN_I && SLOW_CLOCK_TICK_I && bod_wake) |=> WAKE_REQ_O;
	endproperty
	a_brownout: assert property (p_brownout) else $error("brownout alarm did not wake");

	property p_no_source;
		(CLK_EN_I && SLOW_CLOCK_TICK_I && !force_hit && !rtc_wake && in_hit == '0
			&& BROWNOUT_SAMPLE_PERIOD_I == supc_pkg::BOD_DISABLED) |=> !WAKE_REQ_O;
	endproperty
	a_no_source: assert property (p_no_source) else $error("wake without any source");

	property p_tick_only;
		(CLK_EN_I && !SLOW_CLOCK_TICK_I) |=> $stable(WAKE_REQ_O);
	endproperty
	a_tick_only: assert property (p_tick_only) else $error("wake moved between slow edges");

	property p_read_inputs;
		(CLK_EN_I && RD_I && ADDR_I == supc_pkg::WAKE_INPUT_OFFSET) |=> RDATA_O == $past(s_q.inputs);
	endproperty
	a_read_inputs: assert property (p_read_inputs) else $error("wake input readback wrong");

endmodule

`default_nettype wire

// ==== sim/wake_source_model.sv ====
/*
 far-side model of the wake sources: slow-clock tick, force-wake pin, alarms and wake inputs.
 assumes the bench sets the wanted source levels right after rising core clock edges.
*/
`default_nettype none

module wake_source_model #(
	parameter int TICK_DIV = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic force_low_i,
	input wire logic alarm_bo_i,
	input wire logic alarm_rtc_i,
	input wire logic [15:0] wake_i,
	output logic tick_o,
	output logic pin_n_o,
	output logic bo_o,
	output logic rtc_o,
	output logic [15:0] wake_o
);
	timeunit 1ns;
	timeprecision 1ns;

	int cnt;

	// ==========
	// slow clock
	// one tick per period
	// slow clock kept a small fixed ratio so debounce counts stay short
	always @(posedge clk_i)
	begin
		if (rst_i)
			cnt <= 0;
		else
			cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
		tick_o <= !rst_i && cnt == TICK_DIV - 1;
	end

	// ==========
	// sources
	// pin is active low
	assign pin_n_o = !force_low_i;
	assign bo_o = alarm_bo_i;
	assign rtc_o = alarm_rtc_i;
	assign wake_o = wake_i;
endmodule

`default_nettype wire

// ==== sim/tb.sv ====
/*
 self-checking bench of the supply mode and wake-up control block.
 assumes the wake source model makes the slow-clock tick every fourth core cycle.
*/
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ns;

	// longest debounce shortened so code 5 stays cheap to run
	localparam logic [15:0] LONG = 16'h0005;
	logic clk, rst, en, wr, rd, eof, loss, xcmd, force_low, bo, rtc, tick, pin_n, bo_w, rtc_w;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [2:0] bo_per, level;
	logic [15:0] win, win_w;
	logic lcd_ext, lcd_int, pump, deep, core_rst, bram, rtcp, flash, byp, slow, wake;
	logic [3:0] plevel;
	int n_mismatch = 0;
	int checked = 0;
	int lims[6] = '{1, 3, 32, 512, 4096, 5};
	logic [2:0] lv[6] = '{3'h2, 3'h0, 3'h4, 3'h1, 3'h7, 3'h3};
	logic [2:0] lx[6] = '{3'h2, 3'h2, 3'h4, 3'h4, 3'h5, 3'h3};
	wire [12:0] pack = {plevel, deep, level, bram, rtcp, flash, byp, slow};

	// ==========
	// instances
	supply_mode_and_wakeup_control #(.NUM_WAKE(16), .LONGEST_DEBOUNCE(LONG)) i_dut (
		.CORE_CLK_I(clk), .RESET_I(rst), .CLK_EN_I(en), .SLOW_CLOCK_TICK_I(tick),
		.ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .LCD_EOF_I(eof),
		.REG_LOSS_I(loss), .CRYSTAL_SELECT_CMD_I(xcmd), .FORCE_WAKE_PIN_N_I(pin_n),
		.BROWNOUT_ALARM_I(bo_w), .BROWNOUT_SAMPLE_PERIOD_I(bo_per), .RTC_ALARM_I(rtc_w),
		.WAKE_IN_I(win_w), .RDATA_O(rdata), .LCD_EXT_SEL_O(lcd_ext), .LCD_INT_SEL_O(lcd_int),
		.CHARGE_PUMP_ON_O(pump), .LCD_PUMP_LEVEL_O(plevel), .REG_DEEP_O(deep), .REG_LEVEL_O(level),
		.CORE_RESET_O(core_rst), .BACKUP_RAM_ON_O(bram), .RTC_POWER_ON_O(rtcp),
		.FLASH_POWER_ON_O(flash), .CRYSTAL_BYPASS_O(byp), .SLOW_SRC_CRYSTAL_O(slow), .WAKE_REQ_O(wake)
	);

	wake_source_model #(.TICK_DIV(4)) i_src (
		.clk_i(clk), .rst_i(rst), .force_low_i(force_low), .alarm_bo_i(bo), .alarm_rtc_i(rtc),
		.wake_i(win), .tick_o(tick), .pin_n_o(pin_n), .bo_o(bo_w), .rtc_o(rtc_w), .wake_o(win_w)
	);

	// ==========
	// tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic ticks(input int n);
		repeat (n)
		begin
			@(posedge clk);
			while (tick !== 1'b1)
				@(posedge clk);
		end
	endtask

	// ends one edge after a tick, so the next source change never lands on a tick
	task automatic wake_is(input int n, input logic e);
		ticks(n);
		#1;
		chk({31'h0, wake}, {31'h0, e});
		@(posedge clk);
	endtask

	task automatic complete_run();
		if (n_mismatch == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ==========
	// clock and watchdog
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial
	begin
		#(50 * 40000);
		n_mismatch++;
		complete_run();
	end

	// ==========
	// tests
	initial
	begin
		{rst, wr, rd, eof, loss, xcmd, force_low, bo, rtc} = 9'h100;
		addr = 8'h00;
		en = 1'b1;
		wdata = 32'h0;
		bo_per = 3'h0;
		win = 16'h0080;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rreg(8'h08, 32'h0008_0a00);
		chk({19'h0, pack}, 32'h00a4);
		wreg(8'h08, 32'ha51e_193f);
		loss <= 1'b1;
		step(2);
		chk({19'h0, pack}, 32'h1f9f);
		chk({31'h0, core_rst}, 32'h1);
		wreg(8'h08, 32'h5a00_0000);
		step(2);
		chk({19'h0, pack}, 32'h1f9f);
		rreg(8'h08, 32'h001e_193f);
		wreg(8'h08, 32'ha500_0000);
		step(2);
		chk({19'h0, pack}, 32'h0080);
		chk({31'h0, core_rst}, 32'h0);
		for (int i = 0; i < 6; i++)
		begin
			wreg(8'h08, {20'ha5000, lv[i], 9'h0});
			step(2);
			chk({29'h0, level}, {29'h0, lx[i]});
		end
		wreg(8'h08, 32'ha500_0020);
		step(2);
		chk({29'h0, lcd_ext, lcd_int, pump}, 32'h4);
		wreg(8'h08, 32'ha500_0010);
		step(3);
		chk({29'h0, lcd_ext, lcd_int, pump}, 32'h4);
		@(posedge clk);
		eof <= 1'b1;
		@(posedge clk);
		eof <= 1'b0;
		step(2);
		chk({29'h0, lcd_ext, lcd_int, pump}, 32'h0);
		wreg(8'h08, 32'ha500_0030);
		step(2);
		chk({29'h0, lcd_ext, lcd_int, pump}, 32'h3);
		wreg(8'h08, 32'ha500_0000);
		step(2);
		chk({29'h0, lcd_ext, lcd_int, pump}, 32'h0);
		wreg(8'h0c, 32'hffff_ffff);
		rreg(8'h0c, 32'h0000_770b);
		for (int i = 0; i < 6; i++)
		begin
			wreg(8'h0c, {21'h0, i[2:0], 8'h01});
			force_low <= 1'b1;
			wake_is(lims[i], 1'b0);
			wake_is(1, 1'b1);
			force_low <= 1'b0;
			wake_is(3, 1'b0);
		end
		wreg(8'h0c, 32'h0000_0101);
		force_low <= 1'b1;
		ticks(2);
		force_low <= 1'b0;
		ticks(1);
		force_low <= 1'b1;
		wake_is(3, 1'b0);
		force_low <= 1'b0;
		ticks(3);
		wreg(8'h0c, 32'h0000_0601);
		force_low <= 1'b1;
		wake_is(8, 1'b0);
		wreg(8'h0c, 32'h0000_0000);
		wake_is(3, 1'b0);
		force_low <= 1'b0;
		wreg(8'h10, 32'h0009_0081);
		wake_is(2, 1'b0);
		win[0] <= 1'b1;
		wake_is(2, 1'b1);
		win[0] <= 1'b0;
		wake_is(3, 1'b0);
		win[7] <= 1'b0;
		wake_is(2, 1'b1);
		win[7] <= 1'b1;
		wake_is(3, 1'b0);
		win[3] <= 1'b1;
		wake_is(3, 1'b0);
		rreg(8'h10, 32'h0009_0081);
		wreg(8'h0c, 32'h0000_1000);
		win[0] <= 1'b1;
		wake_is(3, 1'b0);
		wake_is(1, 1'b1);
		win[0] <= 1'b0;
		wake_is(3, 1'b0);
		wreg(8'h0c, 32'h0000_0002);
		bo <= 1'b1;
		wake_is(3, 1'b0);
		bo_per <= 3'h1;
		wake_is(2, 1'b1);
		wreg(8'h0c, 32'h0000_0008);
		wake_is(3, 1'b0);
		rtc <= 1'b1;
		wake_is(2, 1'b1);
		rreg(8'h20, 32'h0000_0001);
		wreg(8'h0c, 32'h0000_0000);
		wake_is(3, 1'b0);
		// a frozen block must drop a keyed write
		en <= 1'b0;
		wreg(8'h08, 32'ha500_0100);
		step(2);
		chk({31'h0, deep}, 32'h0);
		en <= 1'b1;
		wreg(8'h08, 32'ha500_0100);
		step(2);
		chk({31'h0, deep}, 32'h1);
		xcmd <= 1'b1;
		@(posedge clk);
		xcmd <= 1'b0;
		step(3);
		chk({31'h0, slow}, 32'h1);
		complete_run();
	end
endmodule

`default_nettype wire
